// ---- src/slf_status_format.sv ----
// Mask, summary status and input-format register slice with table reload
`timescale 1ns/1ps
module slf_status_format
   import slf_pkg::*;
#(
   parameter int NPLL = 4                        // PLLs and frame pulses watched
) (
   input  wire logic              clk_sys,       // System clock, 100 MHz
   input  wire logic              sys_rst,       // Async reset, active high
   input  wire logic [7:0]        reg_addr,      // Register offset from serial port engine
   input  wire logic [7:0]        reg_wdata,     // Write byte
   input  wire logic              reg_wr,        // One-cycle write strobe
   input  wire logic              reg_rd,        // One-cycle read strobe
   output logic      [7:0]        reg_rdata,     // Read byte, valid with reg_rvalid
   output logic                   reg_rvalid,    // One-cycle read answer
   input  wire logic [NPLL-1:0]   pll_lock,      // Per-PLL lock pins, a in bit 0
   input  wire logic [NPLL-1:0]   frame_align,   // Per frame_start_pulse align pins
   input  wire logic              auto_format_detect_on, // Auto detect enable level
   input  wire logic              det_valid,     // Detector update strobe
   input  wire logic [FMT_W-1:0]  det_code,      // Detected format code
   input  wire logic [7:0]        tbl_first_in,  // Lookup ROM: first_level_table value
   input  wire logic [7:0]        tbl_sec_b_in,  // Lookup ROM: second_level_table_b value
   input  wire logic [7:0]        tbl_sec_c_in,  // Lookup ROM: second_level_table_c value
   input  wire logic [RATE_W-1:0] pll_b_rate_in, // Rate ROM for pll_b_output_format
   input  wire logic [RATE_W-1:0] pll_c_rate_in, // Rate ROM for pll_c_output_format
   output logic                   lock_status,   // Global lock summary
   output logic                   align_status,  // Global align summary
   output logic      [FMT_W-1:0]  format_code,   // Input format code, indexes lookup ROM
   output logic      [7:0]        first_level_table,    // Table output register
   output logic      [7:0]        second_level_table_b, // Table output register
   output logic      [7:0]        second_level_table_c, // Table output register
   output logic      [7:0]        pll_b_output_format,  // Indexes rate ROM b
   output logic      [7:0]        pll_c_output_format,  // Indexes rate ROM c
   output logic      [RATE_W-1:0] pll_b_rate,    // PLL b frame-rate code
   output logic      [RATE_W-1:0] pll_c_rate     // PLL c frame-rate code
);
   localparam int SW = 2 * NPLL + 1;

   logic [7:0]    lock_align_mask;
   logic [SW-1:0] sy1, sy2, sy3, filt;
   logic [NPLL-1:0] lock_f, align_f;
   logic          auto_f;
   logic          wr_fmt, wr_tbl, wr_fmt_b, wr_fmt_c, wr_rate_b, wr_rate_c;
   logic          auto_upd, host_upd, reload_pend, rate_b_pend, rate_c_pend;
   logic [NPLL-1:0] lock_mask, align_mask;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Pins pass three flops; a change counts once the second and third agree
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sy1  <= '0;
         sy2  <= '0;
         sy3  <= '0;
         filt <= '0;
      end else begin
         sy1  <= {auto_format_detect_on, frame_align, pll_lock};
         sy2  <= sy1;
         sy3  <= sy2;
         filt <= (filt & (sy2 ^ sy3)) | (sy3 & ~(sy2 ^ sy3));
      end
   end
   assign lock_f  = filt[NPLL-1:0];
   assign align_f = filt[2*NPLL-1:NPLL];
   assign auto_f  = filt[SW-1];

   // Write decode
   assign wr_fmt    = reg_wr && hit(reg_addr, OFS_IN_FMT);
   assign wr_tbl    = reg_wr && (hit(reg_addr, OFS_TBL_FIRST) || hit(reg_addr, OFS_TBL_SEC_B)
                                 || hit(reg_addr, OFS_TBL_SEC_C));
   assign wr_fmt_b  = reg_wr && hit(reg_addr, OFS_PLL_B_FMT);
   assign wr_fmt_c  = reg_wr && hit(reg_addr, OFS_PLL_C_FMT);
   assign wr_rate_b = reg_wr && hit(reg_addr, OFS_PLL_B_RATE);
   assign wr_rate_c = reg_wr && hit(reg_addr, OFS_PLL_C_RATE);
   assign auto_upd  = auto_f && det_valid;
   assign host_upd  = !auto_f && wr_fmt;

   // Mask register, plain read/write
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         lock_align_mask <= MASK_RESET;
      else if (reg_wr && hit(reg_addr, OFS_MASK))
         lock_align_mask <= reg_wdata;
   end
   assign lock_mask  = lock_align_mask[MASK_LOCK_LSB +: NPLL];
   assign align_mask = lock_align_mask[MASK_ALIGN_LSB +: NPLL];

   // Summaries: a masked source counts as good
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lock_status  <= 1'b0;
         align_status <= 1'b0;
      end else begin
         lock_status  <= &(lock_f | lock_mask);
         align_status <= &(align_f | align_mask);
      end
   end

   // Format code: detector beats host, a real update beats the custom marker
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         format_code <= FMT_RESET;
      else if (auto_upd)
         format_code <= det_code;
      else if (host_upd)
         format_code <= reg_wdata[FMT_W-1:0];
      else if (wr_tbl)
         format_code <= FMT_CUSTOM;
   end

   // Reload is one cycle late so the lookup ROM sees the new code first
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst)
         reload_pend <= 1'b0;
      else
         reload_pend <= auto_upd || host_upd;
   end

   // Table output registers; a host write in the reload cycle is overrun by the reload
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         first_level_table    <= TBL_RESET;
         second_level_table_b <= TBL_RESET;
         second_level_table_c <= TBL_RESET;
      end else if (reload_pend) begin
         first_level_table    <= tbl_first_in;
         second_level_table_b <= tbl_sec_b_in;
         second_level_table_c <= tbl_sec_c_in;
      end else if (reg_wr) begin
         if (hit(reg_addr, OFS_TBL_FIRST))
            first_level_table <= reg_wdata;
         if (hit(reg_addr, OFS_TBL_SEC_B))
            second_level_table_b <= reg_wdata;
         if (hit(reg_addr, OFS_TBL_SEC_C))
            second_level_table_c <= reg_wdata;
      end
   end

   // Per-PLL output format registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pll_b_output_format <= OUT_FMT_RESET;
         pll_c_output_format <= OUT_FMT_RESET;
         rate_b_pend         <= 1'b0;
         rate_c_pend         <= 1'b0;
      end else begin
         if (wr_fmt_b)
            pll_b_output_format <= reg_wdata;
         if (wr_fmt_c)
            pll_c_output_format <= reg_wdata;
         rate_b_pend <= wr_fmt_b;
         rate_c_pend <= wr_fmt_c;
      end
   end

   // Rate codes: a direct write is a custom change and reads back as the marker
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pll_b_rate <= RATE_B_RESET;
         pll_c_rate <= RATE_C_RESET;
      end else begin
         if (wr_rate_b)
            pll_b_rate <= RATE_CUSTOM;
         else if (rate_b_pend)
            pll_b_rate <= pll_b_rate_in;
         if (wr_rate_c)
            pll_c_rate <= RATE_CUSTOM;
         else if (rate_c_pend)
            pll_c_rate <= pll_c_rate_in;
      end
   end

   // Read mux; reserved and unmapped offsets read as zero
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               OFS_MASK:       reg_rdata <= lock_align_mask;
               OFS_IN_FMT:     reg_rdata <= {2'h0, format_code};
               OFS_TBL_FIRST:  reg_rdata <= first_level_table;
               OFS_TBL_SEC_B:  reg_rdata <= second_level_table_b;
               OFS_TBL_SEC_C:  reg_rdata <= second_level_table_c;
               OFS_PLL_B_FMT:  reg_rdata <= pll_b_output_format;
               OFS_PLL_C_FMT:  reg_rdata <= pll_c_output_format;
               OFS_PLL_B_RATE: reg_rdata <= {4'h0, pll_b_rate};
               OFS_PLL_C_RATE: reg_rdata <= {4'h0, pll_c_rate};
               default:        reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Checks
   lock_on_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (&(lock_f | lock_mask)) |=> lock_status)
      else $error("lock summary low with all unmasked PLLs locked");
   lock_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !(&(lock_f | lock_mask)) |=> !lock_status)
      else $error("lock summary high with an unmasked PLL unlocked");
   align_sum_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 align_status == $past(&(align_f | align_mask)))
      else $error("align summary does not follow masked align inputs");
   auto_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (auto_f && !det_valid && wr_fmt) |=> $stable(format_code))
      else $error("host changed format code while auto detect on");
   auto_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      auto_upd |=> format_code == $past(det_code))
      else $error("detected code not loaded");
   host_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (host_upd && !det_valid) |=> format_code == $past(reg_wdata[FMT_W-1:0]))
      else $error("host format write not taken");
   tbl_reload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (auto_upd || host_upd) |-> ##2 first_level_table == $past(tbl_first_in)
         && second_level_table_c == $past(tbl_sec_c_in))
      else $error("tables not reloaded after format update");
   custom_fmt_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (wr_tbl && !auto_upd && !host_upd) |=> format_code == FMT_CUSTOM)
      else $error("table write did not mark format custom");
   fmt_reset_a: assert property (@(posedge clk_sys)
      sys_rst |-> format_code == FMT_RESET)
      else $error("format code not zero in reset");
   rate_fresh_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (wr_fmt_b ##1 !wr_rate_b) |=> pll_b_rate == $past(pll_b_rate_in))
      else $error("pll b rate not refreshed after format write");
   rate_mark_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wr_rate_c |=> pll_c_rate == RATE_CUSTOM)
      else $error("pll c rate not marked custom");

   auto_cov_c:   cover property (@(posedge clk_sys) disable iff (sys_rst) auto_upd ##2 1'b1);
   custom_cov_c: cover property (@(posedge clk_sys) disable iff (sys_rst) host_upd ##[1:4] wr_tbl);
   mask_cov_c:   cover property (@(posedge clk_sys) disable iff (sys_rst)
      lock_status && !(&lock_f));
endmodule

// ---- src/slf_pkg.sv ----
// Constants for the lock/align mask and input-format lookup register slice
// How it works
// - Mask bits 7..4 drop PLL d, c, b, a lock from the lock summary.
// - Mask bits 3..0 drop frame pulse d, c, b, a alignment from align summary.
// - Auto detect on: host writes to input format ignored, detector loads it.
// - Auto detect off: host writes input format over the management port.
// - Every detector or host format code update reloads first-level and both second-level table outputs.
// - Host write to any table output register forces format code to 62 unless a detector update lands in the same cycle.
// - Input format register resets to zero.
// - Output format write refreshes that PLL rate code; custom change sets 14.
package slf_pkg;
   // Register offsets
   localparam logic [7:0] OFS_PLL_B_FMT   = 8'h07;
   localparam logic [7:0] OFS_PLL_C_FMT   = 8'h08;
   localparam logic [7:0] OFS_MASK        = 8'h1D;
   localparam logic [7:0] OFS_RSVD_A      = 8'h1E;
   localparam logic [7:0] OFS_RSVD_B      = 8'h1F;
   localparam logic [7:0] OFS_IN_FMT      = 8'h20;
   localparam logic [7:0] OFS_PLL_B_RATE  = 8'h22;
   localparam logic [7:0] OFS_PLL_C_RATE  = 8'h23;
   localparam logic [7:0] OFS_TBL_FIRST   = 8'h28;
   localparam logic [7:0] OFS_TBL_SEC_B   = 8'h29;
   localparam logic [7:0] OFS_TBL_SEC_C   = 8'h2A;
   // Field positions of the mask register
   localparam int         MASK_LOCK_LSB   = 4;
   localparam int         MASK_ALIGN_LSB  = 0;
   // Field widths
   localparam int         FMT_W           = 6;
   localparam int         RATE_W          = 4;
   // Reset and marker values
   localparam logic [5:0] FMT_RESET       = 6'h00;
   localparam logic [5:0] FMT_CUSTOM      = 6'h3E;
   localparam logic [3:0] RATE_CUSTOM     = 4'hE;
   localparam logic [3:0] RATE_B_RESET    = 4'h5;
   localparam logic [3:0] RATE_C_RESET    = 4'h6;
   localparam logic [7:0] MASK_RESET      = 8'h00;
   localparam logic [7:0] OUT_FMT_RESET   = 8'h00;
   localparam logic [7:0] TBL_RESET       = 8'h00;
endpackage

// ---- test/slf_rom_model.sv ----
// Lookup and rate ROM model standing behind the register slice
`timescale 1ns/1ps
module slf_rom_model
   import slf_pkg::*;
(
   input  wire logic [FMT_W-1:0]  format_code, // Index from the slice
   input  wire logic [7:0]        fmt_b,       // PLL b output format
   input  wire logic [7:0]        fmt_c,       // PLL c output format
   output logic      [7:0]        tbl_first,   // first_level_table answer
   output logic      [7:0]        tbl_sec_b,   // second_level_table_b answer
   output logic      [7:0]        tbl_sec_c,   // second_level_table_c answer
   output logic      [RATE_W-1:0] rate_b,      // Rate answer for PLL b
   output logic      [RATE_W-1:0] rate_c       // Rate answer for PLL c
);
   // Distinct contents per table, so a swapped or missed reload shows up
   always_comb begin
      tbl_first = {2'h0, format_code} + 8'h10;
      tbl_sec_b = {2'h0, format_code} ^ 8'hA5;
      tbl_sec_c = {2'h0, format_code} + 8'h40;
      rate_b    = fmt_b[3:0] + 4'h1;
      rate_c    = fmt_c[3:0] + 4'h2;
   end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the mask, summary and input-format slice
`timescale 1ns/1ps
module testbench
   import slf_pkg::*;
;
   logic clk_sys, sys_rst, reg_wr, reg_rd, reg_rvalid, auto_on, det_valid;
   logic lock_status, align_status;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, t1, t2, t3, fb, fc, rd_byte;
   logic [3:0] pll_lock, frame_align, rb_in, rc_in, rb, rc;
   logic [5:0] det_code, fcode;
   int err_count, samples_checked;

   slf_status_format i_slf_status_format (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pll_lock(pll_lock),
      .frame_align(frame_align), .auto_format_detect_on(auto_on), .det_valid(det_valid),
      .det_code(det_code), .tbl_first_in(t1), .tbl_sec_b_in(t2), .tbl_sec_c_in(t3),
      .pll_b_rate_in(rb_in), .pll_c_rate_in(rc_in), .lock_status(lock_status),
      .align_status(align_status), .format_code(fcode), .first_level_table(),
      .second_level_table_b(), .second_level_table_c(), .pll_b_output_format(fb),
      .pll_c_output_format(fc), .pll_b_rate(rb), .pll_c_rate(rc));
   slf_rom_model i_slf_rom_model (.format_code(fcode), .fmt_b(fb), .fmt_c(fc),
      .tbl_first(t1), .tbl_sec_b(t2), .tbl_sec_c(t3), .rate_b(rb_in), .rate_c(rc_in));

   // Free-running system clock, 10 ns period
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One write strobe; the strobe is dropped at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1;
   endtask

   // Read answer is registered, so it is looked at just after the taking edge
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({7'h0, reg_rvalid}, 8'h01);
      rd_byte = reg_rdata;
   endtask

   // Pins pass a 3-flop synchroniser; allow settling before looking
   task automatic settle();
      repeat (7) @(posedge clk_sys);
      #1;
   endtask

   task automatic check_tables(input logic [5:0] c);
      rd(OFS_TBL_FIRST); chk(rd_byte, {2'h0, c} + 8'h10);
      rd(OFS_TBL_SEC_B); chk(rd_byte, {2'h0, c} ^ 8'hA5);
      rd(OFS_TBL_SEC_C); chk(rd_byte, {2'h0, c} + 8'h40);
   endtask

   task automatic t_reset();
      chk({2'h0, fcode}, 8'h00);
      chk({4'h0, rb}, 8'h05);
      rd(OFS_IN_FMT); chk(rd_byte, 8'h00);
      rd(OFS_RSVD_A); chk(rd_byte, 8'h00);
      wr(OFS_RSVD_B, 8'h5A); rd(OFS_RSVD_B); chk(rd_byte, 8'h00);
   endtask

   // Each PLL and each frame pulse dropped in turn, masked and unmasked
   task automatic t_mask();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         pll_lock <= ~(4'h1 << i); frame_align <= ~(4'h1 << i);
         wr(OFS_MASK, 8'h10 << i); settle();
         chk({7'h0, lock_status}, 8'h01);
         chk({7'h0, align_status}, 8'h00);
         wr(OFS_MASK, 8'h01 << i); settle();
         chk({7'h0, lock_status}, 8'h00);
         chk({7'h0, align_status}, 8'h01);
         rd(OFS_MASK); chk(rd_byte, 8'h01 << i);
      end
      wr(OFS_MASK, 8'h00);
      @(posedge clk_sys);
      pll_lock <= 4'hF; frame_align <= 4'hF;
      settle();
      chk({6'h0, lock_status, align_status}, 8'h03);
   endtask

   task automatic t_host_fmt();
      wr(OFS_IN_FMT, 8'h2B); chk({2'h0, fcode}, 8'h2B);
      rd(OFS_IN_FMT); chk(rd_byte, 8'h2B);
      check_tables(6'h2B);
      wr(OFS_TBL_SEC_B, 8'h77); chk({2'h0, fcode}, 8'h3E);
      rd(OFS_TBL_SEC_B); chk(rd_byte, 8'h77);
      wr(OFS_IN_FMT, 8'h11); check_tables(6'h11);
      wr(OFS_TBL_FIRST, 8'h01); chk({2'h0, fcode}, 8'h3E);
   endtask

   task automatic t_auto_fmt();
      @(posedge clk_sys);
      auto_on <= 1'b1;
      settle();
      wr(OFS_IN_FMT, 8'h05); chk({2'h0, fcode}, 8'h3E);
      @(posedge clk_sys);
      det_valid <= 1'b1; det_code <= 6'h27;
      @(posedge clk_sys);
      det_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({2'h0, fcode}, 8'h27);
      check_tables(6'h27);
      @(posedge clk_sys);
      auto_on <= 1'b0;
      settle();
      // With auto detect off a detector strobe must not touch the code
      @(posedge clk_sys);
      det_valid <= 1'b1;
      det_code <= 6'h15;
      @(posedge clk_sys);
      det_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({2'h0, fcode}, 8'h27);
   endtask

   task automatic t_rates();
      wr(OFS_PLL_B_FMT, 8'h03); chk({4'h0, rb}, 8'h04);
      wr(OFS_PLL_C_FMT, 8'h09); chk({4'h0, rc}, 8'h0B);
      wr(OFS_PLL_C_RATE, 8'h02); chk({4'h0, rc}, 8'h0E);
      rd(OFS_PLL_B_RATE); chk(rd_byte, 8'h04);
      rd(OFS_PLL_B_FMT); chk(rd_byte, 8'h03);
      rd(OFS_PLL_C_FMT); chk(rd_byte, 8'h09);
   endtask

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence, reset held for five cycles
   initial begin
      err_count = 0; samples_checked = 0;
      sys_rst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      pll_lock = 4'hF; frame_align = 4'hF; auto_on = 1'b0; det_valid = 1'b0;
      det_code = 6'h00;
      // Raise reset after time zero so the async reset sees a clean edge
      #1;
      sys_rst = 1'b1;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      t_reset();
      t_mask();
      t_host_fmt();
      t_auto_fmt();
      t_rates();
      test_done();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need
   initial begin
      #200000;
      err_count++;
      test_done();
   end
endmodule
